// ---- core/cfg_pkg.sv ----
// Constants, field layout and carrier types of the interface clock and frame generator.
// Assumes an 8-bit register port with a 3-bit word address.
package cfg_pkg;
  // Register offsets.
  localparam logic [2:0] OFF_MODE1 = 3'h0;
  localparam logic [2:0] OFF_MODE2 = 3'h1;
  localparam logic [2:0] OFF_BITS  = 3'h2;
  localparam logic [2:0] OFF_TIMER = 3'h3;
  localparam logic [2:0] OFF_CMD   = 3'h4;
  localparam logic [2:0] OFF_STAT  = 3'h5;
  localparam logic [2:0] OFF_COUNT = 3'h6;
  // Field positions.
  localparam int CSS_POS    = 7;
  localparam int PRESC_LSB  = 4;
  localparam int IMODE_LSB  = 2;
  localparam int SHAPE_LSB  = 5;
  localparam int DBL_POS    = 4;
  localparam int BITSHI_LSB = 0;
  localparam int START_POS  = 0;
  localparam int STOP_POS   = 1;
  localparam int RUN_POS    = 0;
  localparam int SF_POS     = 1;
  // Reset values.
  localparam logic [7:0] MODE1_RST = 8'h00;
  localparam logic [7:0] MODE2_RST = 8'h00;
  localparam logic [9:0] BITS_RST  = 10'h0FF;
  // Prescaler codes.
  localparam logic [1:0] PRESC_DIV2  = 2'h0;
  localparam logic [1:0] PRESC_DIV15 = 2'h1;
  localparam logic [1:0] PRESC_DIV1  = 2'h2;
  localparam logic [1:0] PRESC_BAD   = 2'h3;
  // Interface modes.
  localparam logic [1:0] IM0 = 2'h0;
  localparam logic [1:0] IM1 = 2'h1;
  localparam logic [1:0] IM2 = 2'h2;
  localparam logic [1:0] IM3 = 2'h3;
  // Frame pulse shapes.
  localparam logic [2:0] SH_M0   = 3'h0;
  localparam logic [2:0] SH_M1   = 3'h1;
  localparam logic [2:0] SH_M2   = 3'h2;
  localparam logic [2:0] SH_M3   = 3'h3;
  localparam logic [2:0] SH_M4   = 3'h4;
  localparam logic [2:0] SH_RSVD = 3'h5;
  localparam logic [2:0] SH_M6   = 3'h6;
  localparam logic [2:0] SH_M7   = 3'h7;
  // Bit positions within a frame.
  localparam logic [9:0] MARK_BIT  = 10'h0FB;
  localparam logic [9:0] WIDE_BITS = 10'h020;
  localparam logic [9:0] M4_START  = 10'h010;
  localparam logic [9:0] TS3_LAST  = 10'h01F;
  // Timer pacing, in frames of the 8 kHz structure.
  localparam int FRAME_US    = 125;
  localparam int STEP_US     = 250;
  localparam int STEP_FRAMES = STEP_US / FRAME_US;

  typedef struct packed {
    logic       clock_source_select;
    logic [1:0] presc;
    logic [1:0] imode;
    logic [2:0] shape;
    logic       dbl;
    logic [9:0] bits_m1;
  } cfg_cfg_t;

  typedef enum logic [1:0] {CFG_TMR_STOP, CFG_TMR_ARM, CFG_TMR_RUN} cfg_tmr_t;
endpackage

// ---- core/cfg_clock_frame_gen.sv ----
// Clock source selection, prescaler, data clock and frame pulse generation of the port.
// Assumes all pins are synchronous to i_sys_clk, which runs well above the source clocks.
//
// What this block does
// - PCM side always framed by the PCM clock and frame inputs.
// - Source select 0: reference from PCM clock, drive clock and frame pins.
// - Source select 1: reference from external clock, frames from external frame.
// - Prescaler 00 divides by 2, 01 by 1.5, 10 by 1; 11 forbidden.
// - Interface mode 2 runs the reference at half the data rate.
// - Clock rate bit 0 gives data clock at data rate; PCM mode only.
// - Clock rate bit 1 doubles data clock, only in modes 0 and 3 with source select 0.
// - PCM mode drives frame output shaped by the framing field, unshifted.
// - Framing field selects modes 0 to 7; code 5 reserved.
// - Mode 0: active-low one-bit pulse marking bit 251.
// - Mode 1: mode 0 pulse delayed one timing event: half a reference period, a whole one in interface mode 3.
// - Mode 2: mode 3 pulse advanced one timing event: half a reference period, a whole one in interface mode 3.
// - Mode 3: pulse one bit wide, two data-clock periods when the data clock is doubled.
// - Mode 4: pulse rises at timeslot 2 instead of timeslot 0.
// - Mode 6: rises at timeslot 0 bit 7, high for 32 bits.
// - Mode 7: mode 3 shape one frame per timer expiry, else mode 6.
// - Start loads inverted timer value; steps after timeslot 3, then every 250 us.
// - Timer at zero raises interrupt and next pulse takes mode 3 shape.
// - Timer stopped in mode 7 gives only the mode 6 shape.
// - Selected frame input starts the frame on a rising sampled level.
// - Interface mode field selects port arrangement and bit pacing.
`timescale 1ns/100ps
module cfg_clock_frame_gen #(
  parameter int TIMER_W = 7
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  input  wire logic       i_pcm_clock_in,
  input  wire logic       i_pcm_frame_in,
  input  wire logic       i_data_clock_pin,
  input  wire logic       i_frame_pin,
  output logic            o_data_clock_pin,
  output logic            o_data_clock_pin_oe,
  output logic            o_frame_pin,
  output logic            o_frame_pin_oe,
  output logic            o_reference_clock,
  output logic            o_pcm_frame_start,
  output logic            o_timer_irq
);
  if (TIMER_W < 1 || TIMER_W > 7) begin : g_chk
    $error("TIMER_W must lie between 1 and 7");
  end

  cfg_pkg::cfg_cfg_t     cfg;
  cfg_pkg::cfg_tmr_t     state;
  logic [TIMER_W-1:0]    superframe_timer_value;
  logic [TIMER_W-1:0]    tcount;
  logic [TIMER_W-1:0]    next_tcount;
  logic                  step;
  logic                  sf_pend;
  logic                  sf_frame;
  logic                  src_clk;
  logic                  src_frm;
  logic                  src_q;
  logic                  src_rise;
  logic                  src_edge;
  logic                  ref_clk;
  logic                  ref_q;
  logic [1:0]            pcnt;
  logic                  ev;
  logic [1:0]            epb_m1;
  logic [1:0]            phase;
  logic [9:0]            bitn;
  logic                  fs_cap;
  logic                  sync;
  logic                  bit_end;
  logic                  ts3_pass;
  logic                  pcm_q;
  logic                  pcm_fs_cap;
  logic                  start_cmd;
  logic                  stop_cmd;
  logic                  tick_inc;
  logic                  dbl_eff;
  logic [2:0]            eff_shape;
  logic                  frm_lvl;
  logic                  dclk_lvl;

  assign start_cmd = i_wr && i_addr == cfg_pkg::OFF_CMD && i_wdata[cfg_pkg::START_POS];
  assign stop_cmd  = i_wr && i_addr == cfg_pkg::OFF_CMD && i_wdata[cfg_pkg::STOP_POS];

  // Configuration writes.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cfg.clock_source_select     <= cfg_pkg::MODE1_RST[cfg_pkg::CSS_POS];
      cfg.presc   <= cfg_pkg::MODE1_RST[cfg_pkg::PRESC_LSB +: 2];
      cfg.imode   <= cfg_pkg::MODE1_RST[cfg_pkg::IMODE_LSB +: 2];
      cfg.shape   <= cfg_pkg::MODE2_RST[cfg_pkg::SHAPE_LSB +: 3];
      cfg.dbl     <= cfg_pkg::MODE2_RST[cfg_pkg::DBL_POS];
      cfg.bits_m1 <= cfg_pkg::BITS_RST;
      superframe_timer_value        <= '0;
    end else if (i_wr) begin
      if (i_addr == cfg_pkg::OFF_MODE1) begin
        cfg.clock_source_select   <= i_wdata[cfg_pkg::CSS_POS];
        cfg.imode <= i_wdata[cfg_pkg::IMODE_LSB +: 2];
        // A forbidden divisor would leave the reference clock undefined.
        if (i_wdata[cfg_pkg::PRESC_LSB +: 2] != cfg_pkg::PRESC_BAD) begin
          cfg.presc <= i_wdata[cfg_pkg::PRESC_LSB +: 2];
        end
      end else if (i_addr == cfg_pkg::OFF_MODE2) begin
        cfg.dbl              <= i_wdata[cfg_pkg::DBL_POS];
        cfg.bits_m1[9:8]     <= i_wdata[cfg_pkg::BITSHI_LSB +: 2];
        if (i_wdata[cfg_pkg::SHAPE_LSB +: 3] != cfg_pkg::SH_RSVD) begin
          cfg.shape <= i_wdata[cfg_pkg::SHAPE_LSB +: 3];
        end
      end else if (i_addr == cfg_pkg::OFF_BITS) begin
        cfg.bits_m1[7:0] <= i_wdata;
      end else if (i_addr == cfg_pkg::OFF_TIMER) begin
        superframe_timer_value <= i_wdata[TIMER_W-1:0];
      end
    end
  end

  // Read port; unmapped offsets read as zero.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      if (i_addr == cfg_pkg::OFF_MODE1) begin
        o_rdata <= {cfg.clock_source_select, 1'b0, cfg.presc, cfg.imode, 2'b00};
      end else if (i_addr == cfg_pkg::OFF_MODE2) begin
        o_rdata <= {cfg.shape, cfg.dbl, 2'b00, cfg.bits_m1[9:8]};
      end else if (i_addr == cfg_pkg::OFF_BITS) begin
        o_rdata <= cfg.bits_m1[7:0];
      end else if (i_addr == cfg_pkg::OFF_TIMER) begin
        o_rdata <= 8'({1'b0, superframe_timer_value});
      end else if (i_addr == cfg_pkg::OFF_STAT) begin
        o_rdata <= {6'h00, sf_pend, state != cfg_pkg::CFG_TMR_STOP};
      end else if (i_addr == cfg_pkg::OFF_COUNT) begin
        o_rdata <= 8'({1'b0, tcount});
      end else begin
        o_rdata <= 8'h00;
      end
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // Source selection for the port side only.
  assign src_clk  = cfg.clock_source_select ? i_data_clock_pin : i_pcm_clock_in;
  assign src_frm  = cfg.clock_source_select ? i_frame_pin : i_pcm_frame_in;
  assign src_rise = src_clk && !src_q;
  assign src_edge = src_clk != src_q;

  // Prescaler. Division by 1.5 toggles on two of every three source edges.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      src_q   <= 1'b0;
      ref_clk <= 1'b0;
      ref_q   <= 1'b0;
      pcnt    <= 2'h0;
    end else begin
      src_q <= src_clk;
      ref_q <= ref_clk;
      case (cfg.presc)
        cfg_pkg::PRESC_DIV1: begin
          ref_clk <= src_clk;
        end
        cfg_pkg::PRESC_DIV15: begin
          if (src_edge) begin
            pcnt <= (pcnt == 2'h2) ? 2'h0 : pcnt + 2'h1;
            if (pcnt != 2'h2) begin
              ref_clk <= !ref_clk;
            end
          end
        end
        default: begin
          if (src_rise) begin
            ref_clk <= !ref_clk;
          end
        end
      endcase
    end
  end

  assign o_reference_clock = ref_clk;

  // Timing events per bit: mode 3 and 0 give four, mode 1 two, mode 2 one.
  always_comb begin
    case (cfg.imode)
      cfg_pkg::IM3: epb_m1 = 2'h3;
      cfg_pkg::IM0: epb_m1 = 2'h3;
      cfg_pkg::IM1: epb_m1 = 2'h1;
      default:      epb_m1 = 2'h0;
    endcase
  end

  // Mode 3 counts only rising reference edges, the others both edges.
  assign ev       = (cfg.imode == cfg_pkg::IM3) ? (ref_clk && !ref_q) : (ref_clk != ref_q);
  assign bit_end  = ev && phase == epb_m1;
  assign ts3_pass = bit_end && bitn == cfg_pkg::TS3_LAST;

  // Frame input is captured on each rising source edge; a low-to-high step syncs.
  assign sync = src_rise && src_frm && !fs_cap;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      fs_cap <= 1'b0;
    end else if (src_rise) begin
      fs_cap <= src_frm;
    end
  end

  // Bit position inside the frame; the sync wins over a coinciding event.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      phase <= 2'h0;
      bitn  <= 10'h000;
    end else if (sync) begin
      phase <= 2'h0;
      bitn  <= 10'h000;
    end else if (ev) begin
      if (phase == epb_m1) begin
        phase <= 2'h0;
        bitn  <= (bitn == cfg.bits_m1) ? 10'h000 : bitn + 10'h001;
      end else begin
        phase <= phase + 2'h1;
      end
    end
  end

  // The PCM side keeps its own framing whatever the port uses.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pcm_q             <= 1'b0;
      pcm_fs_cap        <= 1'b0;
      o_pcm_frame_start <= 1'b0;
    end else begin
      pcm_q             <= i_pcm_clock_in;
      o_pcm_frame_start <= i_pcm_clock_in && !pcm_q && i_pcm_frame_in && !pcm_fs_cap;
      if (i_pcm_clock_in && !pcm_q) begin
        pcm_fs_cap <= i_pcm_frame_in;
      end
    end
  end

  // Superframe timer, stepped once per 250 us after the first timeslot 3 pass.
  assign next_tcount = tcount + TIMER_W'(1);
  assign tick_inc    = ts3_pass && (state == cfg_pkg::CFG_TMR_ARM ||
                       (state == cfg_pkg::CFG_TMR_RUN && step == 1'(cfg_pkg::STEP_FRAMES - 1)));

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state       <= cfg_pkg::CFG_TMR_STOP;
      tcount      <= '0;
      step        <= 1'b0;
      sf_pend     <= 1'b0;
      o_timer_irq <= 1'b0;
    end else begin
      o_timer_irq <= 1'b0;
      if (sync) begin
        sf_pend <= 1'b0;
      end
      if (stop_cmd) begin
        state   <= cfg_pkg::CFG_TMR_STOP;
        sf_pend <= 1'b0;
      end else if (start_cmd) begin
        state  <= cfg_pkg::CFG_TMR_ARM;
        tcount <= ~superframe_timer_value;
        step   <= 1'b0;
      end else begin
        if (ts3_pass && state == cfg_pkg::CFG_TMR_RUN) begin
          step <= !step;
        end
        if (tick_inc) begin
          state <= cfg_pkg::CFG_TMR_RUN;
          step  <= 1'b0;
          if (next_tcount == '0) begin
            // Expiry wins over a frame start clearing the marker in the same cycle.
            o_timer_irq <= 1'b1;
            sf_pend     <= 1'b1;
            tcount      <= ~superframe_timer_value;
          end else begin
            tcount <= next_tcount;
          end
        end
      end
    end
  end

  // The marker taken at a frame start shapes that frame, unless a stop command clears it first.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sf_frame <= 1'b0;
    end else if (stop_cmd) begin
      sf_frame <= 1'b0;
    end else if (sync) begin
      sf_frame <= sf_pend && state != cfg_pkg::CFG_TMR_STOP;
    end
  end

  assign eff_shape = (cfg.shape != cfg_pkg::SH_M7) ? cfg.shape :
                     (sf_frame ? cfg_pkg::SH_M3 : cfg_pkg::SH_M6);

  // Outside interface mode 3 half a reference period is one timing event; with one event per bit it is a whole bit.
  always_comb begin
    case (eff_shape)
      cfg_pkg::SH_M0: frm_lvl = bitn != cfg_pkg::MARK_BIT;
      cfg_pkg::SH_M1: frm_lvl = !((bitn == cfg_pkg::MARK_BIT && phase != 2'h0) ||
                        (bitn == cfg_pkg::MARK_BIT + 10'h001 && phase == 2'h0));
      cfg_pkg::SH_M2: frm_lvl = (bitn == 10'h000 && phase != epb_m1) ||
                        (bitn == cfg.bits_m1 && phase == epb_m1);
      cfg_pkg::SH_M3: frm_lvl = bitn == 10'h000;
      cfg_pkg::SH_M4: frm_lvl = bitn >= cfg_pkg::M4_START &&
                        bitn < cfg_pkg::M4_START + cfg_pkg::WIDE_BITS;
      default:        frm_lvl = bitn < cfg_pkg::WIDE_BITS;
    endcase
  end

  // Doubling is honoured only where the data clock can carry it.
  assign dbl_eff = cfg.dbl && !cfg.clock_source_select && (cfg.imode == cfg_pkg::IM0 ||
                   cfg.imode == cfg_pkg::IM3);

  // Mode 2 has one event per bit, so its data clock is a short pulse per bit.
  always_comb begin
    case (cfg.imode)
      cfg_pkg::IM2: dclk_lvl = ev;
      cfg_pkg::IM1: dclk_lvl = !phase[0];
      default:      dclk_lvl = dbl_eff ? !phase[0] : !phase[1];
    endcase
  end

  // Pins are driven only while the port runs from the PCM clocks.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_data_clock_pin    <= 1'b0;
      o_data_clock_pin_oe <= 1'b0;
      o_frame_pin         <= 1'b0;
      o_frame_pin_oe      <= 1'b0;
    end else begin
      o_data_clock_pin    <= dclk_lvl;
      o_data_clock_pin_oe <= !cfg.clock_source_select;
      o_frame_pin         <= frm_lvl;
      o_frame_pin_oe      <= !cfg.clock_source_select;
    end
  end

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  presc_keep_a: assert property (
    i_wr && i_addr == cfg_pkg::OFF_MODE1 &&
    i_wdata[cfg_pkg::PRESC_LSB +: 2] == cfg_pkg::PRESC_BAD |=> cfg.presc == $past(cfg.presc))
    else $error("forbidden prescaler code was stored");
  shape_keep_a: assert property (
    i_wr && i_addr == cfg_pkg::OFF_MODE2 &&
    i_wdata[cfg_pkg::SHAPE_LSB +: 3] == cfg_pkg::SH_RSVD |=> cfg.shape != cfg_pkg::SH_RSVD)
    else $error("reserved frame shape was stored");
  pin_drive_a: assert property (
    $fell(cfg.clock_source_select) |=> o_frame_pin_oe && o_data_clock_pin_oe)
    else $error("pins not driven in PCM-sourced mode");
  ext_src_a: assert property (
    cfg.clock_source_select && cfg.presc == cfg_pkg::PRESC_DIV1 |=> o_reference_clock == $past(i_data_clock_pin))
    else $error("reference does not follow external clock");
  div_two_a: assert property (
    cfg.presc == cfg_pkg::PRESC_DIV2 && src_rise |=> o_reference_clock != $past(ref_clk))
    else $error("divide by two missed a toggle");
  sync_align_a: assert property (
    sync |=> bitn == 10'h000 && phase == 2'h0)
    else $error("frame start did not align the bit counter");
  start_load_a: assert property (
    start_cmd && !stop_cmd |=> tcount == ~$past(superframe_timer_value) && state == cfg_pkg::CFG_TMR_ARM)
    else $error("timer start did not load inverse value");
  expire_irq_a: assert property (
    tick_inc && next_tcount == '0 && !stop_cmd && !start_cmd |=> o_timer_irq && sf_pend ##1 !o_timer_irq)
    else $error("timer expiry did not raise a one-cycle interrupt");
  stop_shape_a: assert property (
    state == cfg_pkg::CFG_TMR_STOP && cfg.shape == cfg_pkg::SH_M7 |-> eff_shape == cfg_pkg::SH_M6)
    else $error("stopped timer did not give mode 6 shape");
  mark_low_a: assert property (
    eff_shape == cfg_pkg::SH_M0 && bitn == cfg_pkg::MARK_BIT |=> !o_frame_pin)
    else $error("mode 0 pulse missing at marked bit");
  wide_high_a: assert property (
    eff_shape == cfg_pkg::SH_M6 && bitn == cfg_pkg::TS3_LAST |=> o_frame_pin)
    else $error("mode 6 pulse shorter than 32 bits");
  pcm_frame_a: assert property (
    i_pcm_clock_in && !pcm_q && i_pcm_frame_in && !pcm_fs_cap |=> o_pcm_frame_start)
    else $error("PCM frame start lost");

  expire_c: cover property (o_timer_irq);
  super_frame_c: cover property (sync && sf_pend && cfg.shape == cfg_pkg::SH_M7);
  double_clk_c: cover property (dbl_eff && ev);
endmodule

// ---- testbench/cfg_line_model.sv ----
// Line model: free-running PCM clock and frame, plus an external clock and frame.
// Assumes the bench gates the external pair onto the pins only while the block releases them.
`timescale 1ns/100ps
module cfg_line_model #(
  parameter int PCM_HALF   = 4,
  parameter int EXT_HALF   = 6,
  parameter int FRAME_CLKS = 512 // Keeps the 256-bit port frame above the mode 0 minimum.
) (
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  output logic      o_pcm_clock,
  output logic      o_pcm_frame,
  output logic      o_ext_clock,
  output logic      o_ext_frame
);
  int pcm_div;
  int pcm_per;
  int ext_div;
  int ext_per;

  // Both sources count the one system clock, so they share a master clock.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pcm_div     <= 0;
      pcm_per     <= 0;
      o_pcm_clock <= 1'b0;
      o_pcm_frame <= 1'b0;
    end else if (pcm_div == PCM_HALF - 1) begin
      pcm_div     <= 0;
      o_pcm_clock <= !o_pcm_clock;
      if (o_pcm_clock) begin
        pcm_per     <= (pcm_per + 1) % FRAME_CLKS;
        o_pcm_frame <= ((pcm_per + 1) % FRAME_CLKS) == 0;
      end
    end else begin
      pcm_div <= pcm_div + 1;
    end
  end

  // A different rate and phase from the PCM pair, still on the same master.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ext_div     <= 2;
      ext_per     <= 0;
      o_ext_clock <= 1'b0;
      o_ext_frame <= 1'b0;
    end else if (ext_div == EXT_HALF - 1) begin
      ext_div     <= 0;
      o_ext_clock <= !o_ext_clock;
      if (o_ext_clock) begin
        ext_per     <= (ext_per + 1) % FRAME_CLKS;
        o_ext_frame <= ((ext_per + 1) % FRAME_CLKS) == 0;
      end
    end else begin
      ext_div <= ext_div + 1;
    end
  end
endmodule

// ---- testbench/cfg_clock_frame_gen_test.sv ----
// Self-checking bench of the clock and frame generator.
// Assumes the line model above; the bench resolves the two shared pins from the enables.
`timescale 1ns/100ps
module cfg_clock_frame_gen_test;
  logic       sys_clk;
  logic       rst;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       pcm_clk, pcm_frm, ext_clk, ext_frm;
  logic       dclk_o, dclk_oe, frm_o, frm_oe, ref_clk, frm_start, irq;
  int         err_total, cmp_count, hi_n, ref_n, dclk_n, fs_n, k;
  logic       dclk_pin, frm_pin;

  assign dclk_pin = dclk_oe ? dclk_o : ext_clk;
  assign frm_pin  = frm_oe ? frm_o : ext_frm;

  cfg_line_model cfg_line_model_inst (.i_sys_clk(sys_clk), .i_rst(rst), .o_pcm_clock(pcm_clk),
    .o_pcm_frame(pcm_frm), .o_ext_clock(ext_clk), .o_ext_frame(ext_frm));

  cfg_clock_frame_gen cfg_clock_frame_gen_inst (.i_sys_clk(sys_clk), .i_rst(rst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_pcm_clock_in(pcm_clk),
    .i_pcm_frame_in(pcm_frm), .i_data_clock_pin(dclk_pin), .i_frame_pin(frm_pin),
    .o_data_clock_pin(dclk_o), .o_data_clock_pin_oe(dclk_oe), .o_frame_pin(frm_o),
    .o_frame_pin_oe(frm_oe), .o_reference_clock(ref_clk), .o_pcm_frame_start(frm_start),
    .o_timer_irq(irq));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = !sys_clk;
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk_eq(input logic [7:0] got, input logic [7:0] e);
    cmp_count++;
    if (got !== e) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask

  task automatic chk_near(input int got, input int e, input int tol);
    cmp_count++;
    if (got < e - tol || got > e + tol) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  task automatic chk_reg(input logic [2:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    chk_eq(rdata, e);
  endtask

  // Counts frame-pin high cycles and rising edges of the clocks over n cycles.
  task automatic measure(input int n);
    logic r0, d0;
    hi_n   = 0;
    ref_n  = 0;
    dclk_n = 0;
    fs_n   = 0;
    r0     = ref_clk;
    d0     = dclk_o;
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      hi_n   += int'(frm_o);
      ref_n  += int'(ref_clk && !r0);
      dclk_n += int'(dclk_o && !d0);
      fs_n   += int'(frm_start);
      r0     = ref_clk;
      d0     = dclk_o;
    end
  endtask

  // Waits, bounded, for a pulse on the frame start (sel 0) or the interrupt (sel 1).
  task automatic wait_pulse(input int sel, input int lim);
    k = 0;
    do begin
      @(posedge sys_clk);
      #1;
      k++;
    end while ((sel == 0 ? frm_start : irq) !== 1'b1 && k < lim);
    if (k >= lim)
      chk_eq(8'h00, 8'h01);
  endtask

  task automatic t_reset();
    chk_reg(cfg_pkg::OFF_MODE1, 8'h00);
    chk_reg(cfg_pkg::OFF_MODE2, 8'h00);
    chk_reg(cfg_pkg::OFF_BITS, 8'hFF);
    chk_reg(cfg_pkg::OFF_STAT, 8'h00);
    chk_eq({6'h00, dclk_oe, frm_oe}, 8'h03);
    wr_reg(3'h7, 8'h5A);
    chk_reg(3'h7, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_refuse();
    wr_reg(cfg_pkg::OFF_MODE1, 8'h20);
    wr_reg(cfg_pkg::OFF_MODE1, 8'h3C);
    chk_reg(cfg_pkg::OFF_MODE1, 8'h2C);
    wr_reg(cfg_pkg::OFF_MODE2, 8'hC0);
    wr_reg(cfg_pkg::OFF_MODE2, 8'hA0);
    chk_reg(cfg_pkg::OFF_MODE2, 8'hC0);
    $display("test refuse done");
  endtask

  task automatic t_presc();
    logic [7:0] m [3] = '{8'h20, 8'h00, 8'h10};
    int         e [3] = '{128, 64, 85};
    for (int i = 0; i < 3; i++) begin
      wr_reg(cfg_pkg::OFF_MODE1, m[i]);
      measure(64);
      measure(1024);
      chk_near(ref_n, e[i], 2);
    end
    $display("test prescaler done");
  endtask

  task automatic t_dclk();
    logic [7:0] m1 [6] = '{8'h20, 8'h20, 8'h2C, 8'h2C, 8'h24, 8'h28};
    logic [7:0] m2 [6] = '{8'h00, 8'h10, 8'h00, 8'h10, 8'h00, 8'h00};
    int         e  [6] = '{64, 128, 32, 64, 128, 256};
    for (int i = 0; i < 6; i++) begin
      wr_reg(cfg_pkg::OFF_MODE1, m1[i]);
      wr_reg(cfg_pkg::OFF_MODE2, m2[i]);
      measure(64);
      measure(1024);
      chk_near(dclk_n, e[i], 2);
      chk_near(ref_n, 128, 2);
    end
    wr_reg(cfg_pkg::OFF_MODE1, 8'h20);
    wr_reg(cfg_pkg::OFF_MODE2, 8'h00);
    $display("test data clock done");
  endtask

  task automatic t_ext();
    wr_reg(cfg_pkg::OFF_MODE1, 8'hA0);
    measure(64);
    chk_eq({6'h00, dclk_oe, frm_oe}, 8'h00);
    // Exactly one PCM frame long, so exactly one PCM frame start falls inside it.
    measure(4096);
    chk_near(ref_n, 341, 2);
    chk_near(fs_n, 1, 0);
    wr_reg(cfg_pkg::OFF_MODE1, 8'h20);
    $display("test external source done");
  endtask

  task automatic t_shapes();
    logic [2:0] s [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
    int         e [7] = '{4080, 4080, 16, 16, 512, 512, 512};
    for (int i = 0; i < 7; i++) begin
      wr_reg(cfg_pkg::OFF_MODE2, {s[i], 5'h00});
      wait_pulse(0, 9000);
      measure(4096);
      chk_near(hi_n, e[i], 4);
    end
    $display("test frame shapes done");
  endtask

  task automatic t_timer();
    wr_reg(cfg_pkg::OFF_TIMER, 8'h01);
    wr_reg(cfg_pkg::OFF_CMD, 8'h01);
    chk_reg(cfg_pkg::OFF_COUNT, 8'h7E);
    chk_reg(cfg_pkg::OFF_STAT, 8'h01);
    wait_pulse(1, 13000);
    chk_near(k, 10240, 2100);
    @(posedge sys_clk);
    #1;
    chk_eq({7'h00, irq}, 8'h00);
    chk_reg(cfg_pkg::OFF_STAT, 8'h03);
    chk_reg(cfg_pkg::OFF_COUNT, 8'h7E);
    wait_pulse(0, 9000);
    measure(4096);
    chk_near(hi_n, 16, 4);
    measure(4096);
    chk_near(hi_n, 512, 4);
    // The two superframe settings load their inverses; timeslot 3 is still far off here.
    wr_reg(cfg_pkg::OFF_TIMER, 8'h13);
    wr_reg(cfg_pkg::OFF_CMD, 8'h01);
    chk_reg(cfg_pkg::OFF_COUNT, 8'h6C);
    wr_reg(cfg_pkg::OFF_TIMER, 8'h2F);
    wr_reg(cfg_pkg::OFF_CMD, 8'h01);
    chk_reg(cfg_pkg::OFF_COUNT, 8'h50);
    wr_reg(cfg_pkg::OFF_CMD, 8'h02);
    chk_reg(cfg_pkg::OFF_STAT, 8'h00);
    $display("test timer done");
  endtask

  initial begin
    rst       = 1'b1;
    addr      = 3'h0;
    wdata     = 8'h00;
    wr        = 1'b0;
    rd        = 1'b0;
    err_total = 0;
    cmp_count = 0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_refuse();
    t_presc();
    t_dclk();
    t_ext();
    t_shapes();
    t_timer();
    end_sim();
  end

  // The tests need at most about 96000 cycles, so this limit only trips on a hang.
  initial begin
    repeat (99000) @(posedge sys_clk);
    err_total++;
    end_sim();
  end
endmodule
